// file: rtl/sbad_pkg.sv
// shared constants for the strap boot and address decoder
package sbad_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_KHZ = 10000;
  // current source settling time before a strap is converted
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = (SETTLE_US * CLK_KHZ + 999) / 1000;

  // ==========================================================
  // measurement converter defaults
  localparam int ADC_W_DEF = 10;
  localparam int ADC_FS_MV_DEF = 2500;

  // ==========================================================
  // strap pin order in the measurement sequence
  localparam logic [1:0] PIN_MAIN_BOOT = 2'h0;
  localparam logic [1:0] PIN_AUX_BOOT = 2'h1;
  localparam logic [1:0] PIN_ADDR = 2'h2;
  localparam int PIN_CNT = 3;

  // ==========================================================
  // decision windows in mV, midway between nominal pin voltages (10 uA test current)
  localparam int BOOT_THR_N = 6;
  localparam int BOOT_THR_MV [BOOT_THR_N] = '{175, 350, 575, 825, 1100, 1450};
  // above this the strap is tied to the supply: aux rail off
  localparam int AUX_OFF_MV = 2000;
  localparam int AUX_THR_N = 7;
  localparam int AUX_THR_MV [AUX_THR_N] = '{175, 350, 575, 825, 1100, 1450, 2000};
  localparam logic [3:0] AUX_OFF_IDX = 4'h7;
  localparam int SGL_THR_N = 8;
  localparam int SGL_THR_MV [SGL_THR_N] = '{160, 290, 435, 595, 795, 1055, 1400, 1900};

  // ==========================================================
  // boot voltage codes for 0, 0.9, 1.0, 1.1, 1.2, 1.35, 1.5 V
  localparam logic [7:0] BOOT_VID [7] = '{8'h00, 8'h83, 8'h97, 8'hab, 8'hbf, 8'hdd, 8'hfb};
  localparam logic [7:0] VID_OFF = 8'h00;
  localparam logic [3:0] ADDR_RST = 4'h0;

  // millivolts to converter code
  function automatic int mv_to_code(input int mv, input int w, input int fs_mv);
    return (mv * ((1 << w) - 1)) / fs_mv;
  endfunction : mv_to_code

endpackage : sbad_pkg

// file: rtl/sbad_top.sv
// power-up strap loader: measures boot and address straps, latches the settings
`timescale 1ns/1ps

// What this block does
// R1: decode each rail's boot strap resistor into one of seven boot voltages
// R2: aux strap at supply disables aux rail and its bus address
// R3: source test current into address strap, then measure pin voltage
// R4: latch decoded address at start-up and never change it afterwards
// R5: aux enabled: seven resistors give even main addresses, aux address one higher
// R6: aux disabled: nine resistors give main addresses 0000 through 1000
// R7: targets hold boot voltage until a set command; zero boot waits for command
// R8: boot setting is reported as a VID code, 97h meaning 1.0 V
// R9: classify each sample by windows midway between nominal strap voltages
module sbad_top #(
  parameter int ADC_W = sbad_pkg::ADC_W_DEF,
  parameter int ADC_FS_MV = sbad_pkg::ADC_FS_MV_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // strap measurement
  output logic [2:0] ISRC_EN,
  output logic [1:0] ADC_SEL,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [ADC_W-1:0] ADC_DATA,
  // set-voltage commands from the serial bus logic
  input wire logic SET_VID_STB,
  input wire logic SET_VID_AUX,
  input wire logic [7:0] SET_VID_CODE,
  // latched configuration
  output logic CFG_VALID,
  output logic AUX_EN,
  output logic [7:0] MAIN_BOOT_VID,
  output logic [7:0] AUX_BOOT_VID,
  output logic [3:0] MAIN_ADDR,
  output logic [3:0] AUX_ADDR,
  output logic AUX_ADDR_EN,
  // ramp targets
  output logic [7:0] MAIN_TARGET,
  output logic MAIN_TARGET_VALID,
  output logic [7:0] AUX_TARGET,
  output logic AUX_TARGET_VALID
);

  generate
    if (ADC_W < 8 || ADC_W > 16 || ADC_FS_MV <= sbad_pkg::AUX_OFF_MV) begin : g_bad_cfg
      $error("sbad_top: converter width or full scale cannot resolve the straps");
    end
  endgenerate

  // ==========================================================
  // sequencer
  typedef enum logic [1:0] {S_SETTLE, S_CONV, S_WAIT, S_DONE} sbad_state_t;

  localparam logic [10:0] SETTLE_LAST = 11'(sbad_pkg::SETTLE_CYC - 1);

  sbad_state_t state_r, state_nxt;
  logic [1:0] pin_r, pin_nxt;
  logic [10:0] cnt_r, cnt_nxt;
  logic [ADC_W-1:0] smp_r [sbad_pkg::PIN_CNT];

  wire settle_end = (state_r == S_SETTLE) && (cnt_r == SETTLE_LAST);
  wire conv_taken = (state_r == S_WAIT) && ADC_DONE;
  wire last_pin = (pin_r == sbad_pkg::PIN_ADDR);

  always_comb begin
    state_nxt = state_r;
    pin_nxt = pin_r;
    cnt_nxt = 11'h000;
    case (state_r)
      S_SETTLE: begin
        cnt_nxt = cnt_r + 11'h001;
        if (settle_end) begin
          state_nxt = S_CONV;
        end
      end
      S_CONV: begin
        state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (ADC_DONE) begin
          state_nxt = last_pin ? S_DONE : S_SETTLE;
          pin_nxt = last_pin ? pin_r : pin_r + 2'h1;
        end
      end
      S_DONE: begin
        state_nxt = S_DONE;
      end
      default: begin
        state_nxt = S_SETTLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= S_SETTLE;
      pin_r <= sbad_pkg::PIN_MAIN_BOOT;
      cnt_r <= 11'h000;
    end else begin
      state_r <= state_nxt;
      pin_r <= pin_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // test current flows from settle through conversion end, one pin at a time
  wire src_on = (state_r != S_DONE);
  assign ISRC_EN = src_on ? (3'h1 << pin_r) : 3'h0; // R3
  assign ADC_SEL = pin_r;
  assign ADC_START = (state_r == S_CONV); // R3

  genvar gp;
  generate
    for (gp = 0; gp < sbad_pkg::PIN_CNT; gp++) begin : g_smp
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          smp_r[gp] <= '0;
        end else if (conv_taken && pin_r == 2'(gp)) begin
          smp_r[gp] <= ADC_DATA; // R3
        end
      end
    end
  endgenerate

  // ==========================================================
  // decoding
  logic [3:0] main_idx, aux_idx, dual_idx, sgl_idx;

  sbad_window #(.N(sbad_pkg::BOOT_THR_N), .ADC_W(ADC_W), .FS_MV(ADC_FS_MV),
    .THR_MV(sbad_pkg::BOOT_THR_MV)) u_main (.sample(smp_r[sbad_pkg::PIN_MAIN_BOOT]),
    .idx(main_idx)); // R9
  sbad_window #(.N(sbad_pkg::AUX_THR_N), .ADC_W(ADC_W), .FS_MV(ADC_FS_MV),
    .THR_MV(sbad_pkg::AUX_THR_MV)) u_aux (.sample(smp_r[sbad_pkg::PIN_AUX_BOOT]),
    .idx(aux_idx));
  sbad_window #(.N(sbad_pkg::BOOT_THR_N), .ADC_W(ADC_W), .FS_MV(ADC_FS_MV),
    .THR_MV(sbad_pkg::BOOT_THR_MV)) u_dual (.sample(smp_r[sbad_pkg::PIN_ADDR]),
    .idx(dual_idx));
  sbad_window #(.N(sbad_pkg::SGL_THR_N), .ADC_W(ADC_W), .FS_MV(ADC_FS_MV),
    .THR_MV(sbad_pkg::SGL_THR_MV)) u_sgl (.sample(smp_r[sbad_pkg::PIN_ADDR]),
    .idx(sgl_idx));

  wire aux_on = (aux_idx != sbad_pkg::AUX_OFF_IDX); // R2
  wire [7:0] main_vid = sbad_pkg::BOOT_VID[main_idx[2:0]]; // R1 R8
  wire [7:0] aux_vid = aux_on ? sbad_pkg::BOOT_VID[aux_idx[2:0]] : sbad_pkg::VID_OFF; // R1 R2
  // dual table steps by two so the aux rail can sit one above
  wire [3:0] addr_dec = aux_on ? {dual_idx[2:0], 1'b0} : sgl_idx; // R5 R6
  // load one cycle after the last sample lands, so the address decode already sees it
  wire load_cfg = (state_r == S_DONE) && !CFG_VALID;

  // ==========================================================
  // latched configuration, written once per reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CFG_VALID <= 1'b0;
      AUX_EN <= 1'b0;
      MAIN_BOOT_VID <= sbad_pkg::VID_OFF;
      AUX_BOOT_VID <= sbad_pkg::VID_OFF;
      MAIN_ADDR <= sbad_pkg::ADDR_RST;
      AUX_ADDR <= sbad_pkg::ADDR_RST;
    end else if (load_cfg) begin
      // the address pin can be reused later; only this load ever writes it
      CFG_VALID <= 1'b1; // R4
      AUX_EN <= aux_on; // R2
      MAIN_BOOT_VID <= main_vid; // R1
      AUX_BOOT_VID <= aux_vid; // R1
      MAIN_ADDR <= addr_dec; // R4
      AUX_ADDR <= addr_dec + 4'h1; // R5
    end
  end

  assign AUX_ADDR_EN = CFG_VALID && AUX_EN; // R2

  // ==========================================================
  // ramp targets
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MAIN_TARGET <= sbad_pkg::VID_OFF;
      MAIN_TARGET_VALID <= 1'b0;
      AUX_TARGET <= sbad_pkg::VID_OFF;
      AUX_TARGET_VALID <= 1'b0;
    end else if (load_cfg) begin
      MAIN_TARGET <= main_vid; // R7
      MAIN_TARGET_VALID <= (main_vid != sbad_pkg::VID_OFF); // R7
      AUX_TARGET <= aux_vid; // R7
      AUX_TARGET_VALID <= aux_on && (aux_vid != sbad_pkg::VID_OFF); // R7 R2
    end else if (CFG_VALID && SET_VID_STB) begin
      if (!SET_VID_AUX) begin
        MAIN_TARGET <= SET_VID_CODE; // R7
        MAIN_TARGET_VALID <= 1'b1;
      end else if (AUX_EN) begin
        // a disabled aux rail ignores commands aimed at it
        AUX_TARGET <= SET_VID_CODE; // R7 R2
        AUX_TARGET_VALID <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  localparam logic [ADC_W-1:0] THR0_CODE =
    ADC_W'(sbad_pkg::mv_to_code(sbad_pkg::BOOT_THR_MV[0], ADC_W, ADC_FS_MV));
  localparam logic [ADC_W-1:0] THR5_CODE =
    ADC_W'(sbad_pkg::mv_to_code(sbad_pkg::BOOT_THR_MV[5], ADC_W, ADC_FS_MV));

  logic [10:0] src_age_r;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      src_age_r <= 11'h000;
    end else if (state_r == S_SETTLE && cnt_r == 11'h000) begin
      src_age_r <= 11'h001;
    end else if (src_age_r != 11'h7ff) begin
      src_age_r <= src_age_r + 11'h001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_conv;
    ADC_START ##1 (!ADC_START && ISRC_EN != 3'h0);
  endsequence
  sequence s_cfg_load;
    (state_r == S_DONE && !CFG_VALID) ##1 CFG_VALID;
  endsequence

  chk_src_settled: assert property (ADC_START |-> src_age_r > SETTLE_LAST) // R3
    else $error("conversion started before the test current settled");
  chk_conv_hold: assert property (s_conv |-> ISRC_EN == $past(ISRC_EN)) // R3
    else $error("test current moved during conversion");
  chk_addr_frozen: assert property (CFG_VALID && $past(CFG_VALID) |-> // R4
    $stable(MAIN_ADDR) && $stable(AUX_ADDR) && $stable(AUX_EN))
    else $error("latched address changed");
  chk_dual_addr: assert property (AUX_ADDR_EN |-> // R5
    !MAIN_ADDR[0] && AUX_ADDR == MAIN_ADDR + 4'h1 && MAIN_ADDR <= 4'hc)
    else $error("dual address pair wrong");
  chk_aux_off: assert property (s_cfg_load |-> // R2
    (!AUX_EN == (aux_idx == sbad_pkg::AUX_OFF_IDX)) && (AUX_EN || !AUX_TARGET_VALID))
    else $error("aux shutdown not applied");
  chk_single_map: assert property (s_cfg_load ##0 !AUX_EN |-> MAIN_ADDR == sgl_idx) // R6
    else $error("single address wrong");
  chk_boot_low: assert property (CFG_VALID && smp_r[0] < THR0_CODE |-> // R1
    MAIN_BOOT_VID == 8'h00 && (!$rose(MAIN_TARGET_VALID) || $past(SET_VID_STB)))
    else $error("low strap not decoded as zero boot");
  chk_boot_high: assert property (CFG_VALID && smp_r[0] >= THR5_CODE |-> // R1
    MAIN_BOOT_VID == 8'hfb)
    else $error("top strap not decoded as 1.5 V");
  chk_vid_1v0: assert property (s_cfg_load ##0 main_idx == 4'h2 |-> // R8
    MAIN_BOOT_VID == 8'h97 && MAIN_TARGET == 8'h97 && MAIN_TARGET_VALID)
    else $error("1.0 V boot code wrong");
  chk_target_hold: assert property (CFG_VALID && $past(CFG_VALID) && !$past(SET_VID_STB) |-> // R7
    $stable(MAIN_TARGET) && $stable(MAIN_TARGET_VALID))
    else $error("target moved without a command");

endmodule : sbad_top

// file: rtl/sbad_window.sv
// sorts one converter sample into a table index by threshold windows
`timescale 1ns/1ps

module sbad_window #(
  parameter int N = 6,
  parameter int ADC_W = 10,
  parameter int FS_MV = 2500,
  parameter int THR_MV [N] = '{default: 0}
) (
  // sample in
  input wire logic [ADC_W-1:0] sample,
  // table index out
  output logic [3:0] idx
);

  generate
    if (N < 1 || N > 15) begin : g_bad_n
      $error("sbad_window: N must be 1..15");
    end
  endgenerate

  // ==========================================================
  // one comparator per window edge
  logic [N-1:0] above;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cmp
      localparam logic [ADC_W-1:0] THR_CODE =
        ADC_W'(sbad_pkg::mv_to_code(THR_MV[gi], ADC_W, FS_MV));
      assign above[gi] = (sample >= THR_CODE); // R9
    end
  endgenerate

  // thresholds rise monotonically, so the count of passed edges is the index
  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < N; i++) begin
      idx = idx + {3'h0, above[i]};
    end
  end

endmodule : sbad_window

// file: tb/sbad_strap_model.sv
// strap resistors and measurement converter seen from the loader's pins
`timescale 1ns/1ps

module sbad_strap_model #(
  parameter int ADC_W = 10,
  parameter int FS_MV = 2500
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // loader side
  input wire logic [2:0] isrc_en,
  input wire logic [1:0] adc_sel,
  input wire logic adc_start,
  output logic adc_done,
  output logic [ADC_W-1:0] adc_data,
  // strap values in kohm, ff means tied to supply; lat is the answer delay
  input wire logic [7:0] r_main,
  input wire logic [7:0] r_aux,
  input wire logic [7:0] r_addr,
  input wire logic [7:0] lat
);
  // ==========================================================
  // pin voltage
  logic [7:0] kohm;
  int mv;
  logic [ADC_W-1:0] code;
  logic busy;
  logic [7:0] cnt;
  always_comb begin
    kohm = (adc_sel == 2'h0) ? r_main : ((adc_sel == 2'h1) ? r_aux : r_addr);
    // a resistor only shows a voltage while the test current flows
    mv = (kohm == 8'hff) ? FS_MV : (isrc_en[adc_sel] ? int'(kohm) * 10 : 0);
  end
  assign code = ADC_W'(mv * ((1 << ADC_W) - 1) / FS_MV);

  // ==========================================================
  // conversion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      adc_done <= 1'b0;
      adc_data <= '0;
    end else begin
      adc_done <= 1'b0;
      // outside the done cycle the data is not held
      adc_data <= ~adc_data;
      if (adc_start && lat == 8'h00) begin
        adc_done <= 1'b1;
        adc_data <= code;
      end else if (adc_start) begin
        busy <= 1'b1;
        cnt <= lat - 8'h01;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= code;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : sbad_strap_model

// file: tb/tb_sbad_top.sv
// testbench for the strap boot and address loader
`timescale 1ns/1ps

module tb_sbad_top;
  // ==========================================================
  // signals
  logic CLK, RSTN, ADC_START, ADC_DONE, CFG_VALID, AUX_EN, AUX_ADDR_EN;
  logic SET_VID_STB, SET_VID_AUX, MAIN_TARGET_VALID, AUX_TARGET_VALID;
  logic [2:0] ISRC_EN;
  logic [1:0] ADC_SEL;
  logic [9:0] ADC_DATA;
  logic [7:0] SET_VID_CODE, MAIN_BOOT_VID, AUX_BOOT_VID, MAIN_TARGET, AUX_TARGET;
  logic [3:0] MAIN_ADDR, AUX_ADDR;
  logic [7:0] r_main, r_aux, r_addr, lat;
  int num_errors, total_checks;
  localparam logic [7:0] DUAL_K [7] = '{8'h0a, 8'h19, 8'h2d, 8'h46, 8'h5f, 8'h7d, 8'ha5};
  localparam logic [7:0] SGL_K [9] = '{8'h0a, 8'h16, 8'h24, 8'h33, 8'h44, 8'h5b, 8'h78,
    8'ha0, 8'hdc};

  sbad_top sbad_top_i (.CLK(CLK), .RSTN(RSTN), .ISRC_EN(ISRC_EN), .ADC_SEL(ADC_SEL),
    .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA),
    .SET_VID_STB(SET_VID_STB), .SET_VID_AUX(SET_VID_AUX), .SET_VID_CODE(SET_VID_CODE),
    .CFG_VALID(CFG_VALID), .AUX_EN(AUX_EN), .MAIN_BOOT_VID(MAIN_BOOT_VID),
    .AUX_BOOT_VID(AUX_BOOT_VID), .MAIN_ADDR(MAIN_ADDR), .AUX_ADDR(AUX_ADDR),
    .AUX_ADDR_EN(AUX_ADDR_EN), .MAIN_TARGET(MAIN_TARGET),
    .MAIN_TARGET_VALID(MAIN_TARGET_VALID), .AUX_TARGET(AUX_TARGET),
    .AUX_TARGET_VALID(AUX_TARGET_VALID));
  sbad_strap_model sbad_strap_model_i (.clk(CLK), .rstn(RSTN), .isrc_en(ISRC_EN),
    .adc_sel(ADC_SEL), .adc_start(ADC_START), .adc_done(ADC_DONE), .adc_data(ADC_DATA),
    .r_main(r_main), .r_aux(r_aux), .r_addr(r_addr), .lat(lat));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // ==========================================================
  // shared tasks
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // wait up to n cycles for ADC_START (sel 0) or CFG_VALID (sel 1), sampled after the edge
  task automatic wait_for(input int n, input bit sel);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge CLK);
      #10;
      if ((sel ? CFG_VALID : ADC_START) === 1'b1) return;
    end
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask : wait_for

  task automatic power_up(input logic [7:0] m, input logic [7:0] a, input logic [7:0] ad);
    int p;
    r_main = m;
    r_aux = a;
    r_addr = ad;
    RSTN = 1'b0;
    repeat (3) @(posedge CLK);
    #10 RSTN = 1'b1;
    for (p = 0; p < 3; p++) begin
      wait_for(1100, 1'b0);
      chk(8'(ISRC_EN), 8'(3'h1 << p));
      chk(8'(ADC_SEL), 8'(p));
    end
    wait_for(1100, 1'b1);
    chk(8'(ISRC_EN), 8'h00);
  endtask : power_up

  task automatic cmd(input logic aux, input logic [7:0] code);
    @(posedge CLK);
    #10;
    SET_VID_STB = 1'b1;
    SET_VID_AUX = aux;
    SET_VID_CODE = code;
  endtask : cmd

  task automatic idle();
    @(posedge CLK);
    #10 SET_VID_STB = 1'b0;
  endtask : idle

  // ==========================================================
  // scenarios
  task automatic test_dual();
    int i;
    for (i = 0; i < 7; i++) begin
      power_up(DUAL_K[i], DUAL_K[(i + 3) % 7], DUAL_K[i]);
      chk(MAIN_BOOT_VID, sbad_pkg::BOOT_VID[i]);
      chk(AUX_BOOT_VID, sbad_pkg::BOOT_VID[(i + 3) % 7]);
      chk(8'(MAIN_ADDR), 8'(2 * i));
      chk(8'(AUX_ADDR), 8'(2 * i + 1));
      chk(8'(AUX_ADDR_EN), 8'h01);
      chk(MAIN_TARGET, sbad_pkg::BOOT_VID[i]);
      chk(8'(MAIN_TARGET_VALID), 8'(i != 0));
      chk(8'(AUX_TARGET_VALID), 8'((i + 3) % 7 != 0));
    end
    $display("test dual done");
  endtask : test_dual

  task automatic test_single();
    int i;
    for (i = 0; i < 9; i++) begin
      power_up(DUAL_K[i % 7], 8'hff, SGL_K[i]);
      chk(8'(MAIN_ADDR), 8'(i));
      chk(8'(AUX_EN), 8'h00);
      chk(8'(AUX_ADDR_EN), 8'h00);
      chk(AUX_BOOT_VID, 8'h00);
      chk(8'(AUX_TARGET_VALID), 8'h00);
    end
    $display("test single done");
  endtask : test_single

  // one kohm either side of a window edge: 17k/18k straddle 175 mV, 199k/201k the supply tie
  task automatic test_window();
    power_up(8'h11, 8'hc7, 8'h12);
    chk(MAIN_BOOT_VID, sbad_pkg::BOOT_VID[0]);
    chk(AUX_BOOT_VID, sbad_pkg::BOOT_VID[6]);
    chk(8'(MAIN_ADDR), 8'h02);
    power_up(8'h12, 8'hc9, 8'h11);
    chk(MAIN_BOOT_VID, sbad_pkg::BOOT_VID[1]);
    chk(8'(AUX_EN), 8'h00);
    chk(8'(MAIN_ADDR), 8'h01);
    $display("test window done");
  endtask : test_window

  task automatic test_latch();
    lat = 8'h07;
    power_up(DUAL_K[2], DUAL_K[2], DUAL_K[2]);
    r_addr = DUAL_K[6];
    r_aux = 8'hff;
    repeat (50) @(posedge CLK);
    #10;
    chk(8'(MAIN_ADDR), 8'h04);
    chk(8'(AUX_EN), 8'h01);
    chk(8'(ISRC_EN), 8'h00);
    lat = 8'h00;
    $display("test latch done");
  endtask : test_latch

  task automatic test_setvid();
    power_up(DUAL_K[0], DUAL_K[0], DUAL_K[1]);
    chk(8'(MAIN_TARGET_VALID), 8'h00);
    cmd(1'b1, 8'h3c);
    cmd(1'b0, 8'h77);
    idle();
    chk(AUX_TARGET, 8'h3c);
    chk(8'(AUX_TARGET_VALID), 8'h01);
    chk(MAIN_TARGET, 8'h77);
    chk(8'(MAIN_TARGET_VALID), 8'h01);
    power_up(DUAL_K[4], 8'hff, SGL_K[3]);
    cmd(1'b1, 8'h5a);
    idle();
    chk(8'(AUX_TARGET_VALID), 8'h00);
    chk(MAIN_TARGET, sbad_pkg::BOOT_VID[4]);
    $display("test setvid done");
  endtask : test_setvid

  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    total_checks = 0;
    RSTN = 1'b0;
    SET_VID_STB = 1'b0;
    SET_VID_AUX = 1'b0;
    SET_VID_CODE = 8'h00;
    lat = 8'h00;
    r_main = 8'h0a;
    r_aux = 8'h0a;
    r_addr = 8'h0a;
    test_dual();
    test_window();
    test_single();
    test_latch();
    test_setvid();
    results();
  end
endmodule : tb_sbad_top
